// ===== dvm_conversion_display_mux.sv
// Pulse-modulation voltmeter control: counter chain, latch, display scan, APB
`timescale 1ns/100ps
`default_nettype none
module dvm_conversion_display_mux #(
  parameter int unsigned CONV_CYCLES = dvm_pkg::CONV_CYCLES,
  parameter int unsigned OSC_DIV     = dvm_pkg::OSC_DIV
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        clock_en,
  input  wire logic        comparator_in,
  input  wire logic        polarity_in,
  input  wire logic        ext_clock_in,
  input  wire logic        start_conversion,
  output logic             reference_switch,
  output logic             osc_square_out,
  output logic             conversion_complete,
  output logic             overflow_out,
  output logic             sign_out,
  output logic [6:0]       segments,
  output logic [3:0]       digit_select,
  output logic             irq,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  localparam logic [15:0] CYC_LAST = 16'(CONV_CYCLES - 1);
  // Window end and transfer point keep their distance from the end of the cycle
  localparam logic [15:0] CYC_WIN  =
    16'(CONV_CYCLES - (dvm_pkg::CONV_CYCLES - dvm_pkg::WINDOW_CYCLES));
  localparam logic [15:0] CYC_XFER =
    16'(CONV_CYCLES - (dvm_pkg::CONV_CYCLES - dvm_pkg::XFER_POINT));
  localparam logic [7:0]  GAP      = 8'(dvm_pkg::GAP_CYCLES);
  localparam logic [6:0]  DONE_LAST = 7'(dvm_pkg::DONE_CYCLES - 1);
  localparam logic [4:0]  PRE_LAST = 5'(dvm_pkg::PRESCALE - 1);
  localparam logic [15:0] DIV_LAST = 16'(OSC_DIV - 1);
  localparam logic [15:0] DIV_HALF = 16'(OSC_DIV / 2);
  localparam logic [3:0]  OVER_THOUSANDS = 4'(dvm_pkg::FULL_SCALE / 1000);

  logic comp_s;
  logic pol_s;
  logic ext_s;
  logic start_s;

  dvm_input_sync u_comp  (.clock(clock), .reset(reset), .clock_en(clock_en),
                          .async_in(comparator_in), .sync_out(comp_s));
  dvm_input_sync u_pol   (.clock(clock), .reset(reset), .clock_en(clock_en),
                          .async_in(polarity_in), .sync_out(pol_s));
  dvm_input_sync u_ext   (.clock(clock), .reset(reset), .clock_en(clock_en),
                          .async_in(ext_clock_in), .sync_out(ext_s));
  dvm_input_sync u_start (.clock(clock), .reset(reset), .clock_en(clock_en),
                          .async_in(start_conversion), .sync_out(start_s));

  logic                 rc_mode_q;
  logic                 soft_start_q;
  logic                 ext_prev_q;
  logic [15:0]          div_q;
  logic                 tick;
  logic [15:0]          cyc_q;
  logic                 mod_q;
  logic [4:0]           pre_q;
  logic [3:0][3:0]      bcd_q;
  dvm_pkg::result_t     latch_q;
  logic                 start_prev_q;
  logic                 start_edge;
  logic                 pending_q;
  logic                 xfer_do;
  logic [6:0]           done_cnt_q;
  logic [dvm_pkg::EV_WIDTH-1:0] ev_stat_q;
  logic [dvm_pkg::EV_WIDTH-1:0] ev_mask_q;
  logic [dvm_pkg::EV_WIDTH-1:0] ev_set;
  logic [1:0]           scan_idx;
  logic                 gap;
  logic [3:0]           glyph;
  logic [6:0]           seg_pat;
  logic                 apb_write;

  // Conversion clock: divided RC-style oscillator or synchronised external source
  assign tick = clock_en & (rc_mode_q ? (div_q == DIV_LAST) : (ext_s & ~ext_prev_q));

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      div_q          <= 16'h0000;
      osc_square_out <= 1'b0;
      ext_prev_q     <= 1'b0;
    end
    else if (clock_en)
    begin
      ext_prev_q <= ext_s;
      if (!rc_mode_q)
      begin
        div_q          <= 16'h0000;
        osc_square_out <= 1'b0;
      end
      else
      begin
        div_q          <= (div_q == DIV_LAST) ? 16'h0000 : div_q + 16'h0001;
        osc_square_out <= (div_q < DIV_HALF) ? 1'b0 : 1'b1;
      end
    end
  end

  // Master counter chain; both conversion and scan derive from it
  always_ff @(posedge clock)
  begin
    if (reset)
      cyc_q <= 16'h0000;
    else if (tick)
      cyc_q <= (cyc_q == CYC_LAST) ? 16'h0000 : cyc_q + 16'h0001;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      mod_q <= 1'b0;
    else if (tick)
      mod_q <= comp_s;
  end

  assign reference_switch = mod_q;

  // Gated count, prescaled so a full window of ones reaches 2000
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pre_q <= 5'h00;
      bcd_q <= '0;
    end
    else if (tick)
    begin
      if (cyc_q == CYC_LAST)
      begin
        pre_q <= 5'h00;
        bcd_q <= '0;
      end
      else if ((cyc_q < CYC_WIN) && mod_q)
      begin
        pre_q <= (pre_q == PRE_LAST) ? 5'h00 : pre_q + 5'h01;
        // Saturate at overrange so the count cannot wrap back in range
        if (pre_q == PRE_LAST && bcd_q[3] < OVER_THOUSANDS)
        begin
          for (int i = 0; i < 4; i++)
          begin
            if (i == 0 || bcd_q[i-1] == 4'h9 && (i < 2 || bcd_q[i-2] == 4'h9)
                && (i < 3 || bcd_q[0] == 4'h9))
              bcd_q[i] <= (bcd_q[i] == 4'h9) ? 4'h0 : bcd_q[i] + 4'h1;
          end
        end
      end
    end
  end

  // Start request: any high level arms a transfer, a rising edge also drops done
  assign start_edge = clock_en & ((start_s & ~start_prev_q) | soft_start_q);
  assign xfer_do    = tick & (cyc_q == CYC_XFER) & pending_q & ~start_edge;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      start_prev_q <= 1'b0;
      pending_q    <= 1'b0;
    end
    else if (clock_en)
    begin
      start_prev_q <= start_s;
      if (start_edge || start_s)
        pending_q <= 1'b1;
      else if (xfer_do)
        pending_q <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      latch_q <= '0;
    else if (xfer_do)
    begin
      latch_q.digits   <= bcd_q;
      latch_q.overflow <= (bcd_q[3] >= OVER_THOUSANDS);
      latch_q.sign     <= pol_s;
    end
  end

  assign overflow_out = latch_q.overflow;
  assign sign_out     = latch_q.sign;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      conversion_complete <= 1'b0;
      done_cnt_q          <= 7'h00;
    end
    else if (start_edge)
      conversion_complete <= 1'b0;
    else if (xfer_do)
    begin
      conversion_complete <= 1'b1;
      done_cnt_q          <= 7'h00;
    end
    else if (tick && conversion_complete)
    begin
      done_cnt_q <= done_cnt_q + 7'h01;
      if (done_cnt_q == DONE_LAST)
        conversion_complete <= 1'b0;
    end
  end

  // Display scan from the low bits of the chain; gap at the start of each slot
  assign scan_idx = cyc_q[9:8];
  assign gap      = (cyc_q[7:0] < GAP);

  always_comb
  begin
    if (latch_q.overflow)
    begin
      case (scan_idx)
        2'd3:    glyph = latch_q.sign ? dvm_pkg::GLYPH_BLANK : dvm_pkg::GLYPH_MINUS;
        2'd2:    glyph = dvm_pkg::GLYPH_O;
        2'd1:    glyph = dvm_pkg::GLYPH_F;
        default: glyph = dvm_pkg::GLYPH_L;
      endcase
    end
    else if (scan_idx == 2'd3 && latch_q.digits[3] == 4'h0)
      glyph = dvm_pkg::GLYPH_BLANK;
    else
      glyph = latch_q.digits[scan_idx];
  end

  dvm_seg_decode u_seg (.glyph(glyph), .segments(seg_pat));

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      segments     <= 7'h00;
      digit_select <= 4'h0;
    end
    else if (clock_en)
    begin
      segments     <= gap ? 7'h00 : seg_pat;
      digit_select <= gap ? 4'h0 : 4'(4'h1 << scan_idx);
    end
  end

  // APB slave: one wait state, registered read data
  assign apb_write = psel & penable & pready & pwrite;
  assign ev_set    = {start_edge, xfer_do & (bcd_q[3] >= OVER_THOUSANDS), xfer_do};

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else if (clock_en)
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && penable && !pready)
      begin
        if (paddr == dvm_pkg::CTRL_OFS)
          prdata <= {31'h0, rc_mode_q};
        else if (paddr == dvm_pkg::STATUS_OFS)
          prdata <= {28'h0, pending_q, latch_q.sign, latch_q.overflow,
                     conversion_complete};
        else if (paddr == dvm_pkg::RESULT_OFS)
          prdata <= {16'h0, latch_q.digits};
        else if (paddr == dvm_pkg::IRQ_STAT_OFS)
          prdata <= {29'h0, ev_stat_q};
        else if (paddr == dvm_pkg::IRQ_MASK_OFS)
          prdata <= {29'h0, ev_mask_q};
        else
          pslverr <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rc_mode_q    <= dvm_pkg::CTRL_RC_RESET;
      soft_start_q <= 1'b0;
      ev_mask_q    <= dvm_pkg::IRQ_MASK_RESET;
    end
    else if (clock_en)
    begin
      soft_start_q <= apb_write && paddr == dvm_pkg::CTRL_OFS && pwdata[dvm_pkg::CTRL_START_BIT];
      if (apb_write && paddr == dvm_pkg::CTRL_OFS)
        rc_mode_q <= pwdata[dvm_pkg::CTRL_RC_BIT];
      if (apb_write && paddr == dvm_pkg::IRQ_MASK_OFS)
        ev_mask_q <= pwdata[dvm_pkg::EV_WIDTH-1:0];
    end
  end

  // Set beats a write-one clear in the same cycle
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ev_stat_q <= '0;
      irq       <= 1'b0;
    end
    else if (clock_en)
    begin
      if (apb_write && paddr == dvm_pkg::IRQ_STAT_OFS)
        ev_stat_q <= (ev_stat_q & ~pwdata[dvm_pkg::EV_WIDTH-1:0]) | ev_set;
      else
        ev_stat_q <= ev_stat_q | ev_set;
      irq <= |(ev_stat_q & ev_mask_q);
    end
  end

  chk_cycle_wrap: assert property (@(posedge clock) disable iff (reset)
    (tick && cyc_q == CYC_LAST) |=> cyc_q == 16'h0000)
    else $error("counter chain did not wrap at end of conversion");

  chk_scan_slot: assert property (@(posedge clock) disable iff (reset)
    (clock_en && !gap && cyc_q[9:8] == 2'd2) |=> digit_select == 4'h4)
    else $error("scan slot does not select its digit");

  chk_gap_blank: assert property (@(posedge clock) disable iff (reset)
    (clock_en && cyc_q[7:0] < GAP) |=> digit_select == 4'h0 && segments == 7'h00)
    else $error("digits not blanked in inter-digit gap");

  chk_over_flag: assert property (@(posedge clock) disable iff (reset)
    (xfer_do && bcd_q[3] >= OVER_THOUSANDS) |=> overflow_out ##0 !latch_q.digits[3][3])
    else $error("overrange result did not raise overflow");

  chk_lead_blank: assert property (@(posedge clock) disable iff (reset)
    (clock_en && !gap && scan_idx == 2'd3 && !latch_q.overflow && latch_q.digits[3] == 4'h0)
    |=> segments == 7'h00)
    else $error("zero leading digit was shown");

  chk_sign_latch: assert property (@(posedge clock) disable iff (reset)
    xfer_do |=> sign_out == $past(pol_s))
    else $error("sign not taken with result");

  chk_mod_capture: assert property (@(posedge clock) disable iff (reset)
    tick |=> reference_switch == $past(comp_s))
    else $error("modulator did not capture comparator");

  chk_count_gate: assert property (@(posedge clock) disable iff (reset)
    (tick && cyc_q >= CYC_WIN && cyc_q != CYC_LAST) |=> $stable(bcd_q) && $stable(pre_q))
    else $error("result counter moved outside window");

  chk_done_rise: assert property (@(posedge clock) disable iff (reset)
    $rose(conversion_complete) |-> $past(cyc_q) == CYC_XFER && $past(pending_q))
    else $error("conversion complete rose off the transfer point");

  chk_done_drop: assert property (@(posedge clock) disable iff (reset)
    (tick && conversion_complete && done_cnt_q == DONE_LAST && !xfer_do) |=> !conversion_complete)
    else $error("conversion complete held past its width");

  chk_start_drop: assert property (@(posedge clock) disable iff (reset)
    start_edge |=> !conversion_complete ##0 pending_q)
    else $error("start edge did not drop complete or arm transfer");

  chk_one_digit: assert property (@(posedge clock) disable iff (reset)
    $onehot0(digit_select))
    else $error("more than one digit selected");

  chk_ext_square: assert property (@(posedge clock) disable iff (reset)
    (!rc_mode_q && clock_en) |=> !osc_square_out)
    else $error("square output active outside RC mode");

endmodule // dvm_conversion_display_mux
`default_nettype wire

// ===== dvm_conversion_display_mux_bench.sv
// Self-checking bench for the voltmeter conversion and display block
`timescale 1ns/100ps
`default_nettype none
module dvm_conversion_display_mux_bench;
  localparam int DIV = 2;
  // Half-length conversion keeps the run short
  localparam int CONV = 32256;
  localparam int LIMIT = 80000;
  logic        clock = 1'b0;
  logic        clock_en = 1'b1;
  logic        reset = 1'b1;
  logic        comparator_in = 1'b1;
  logic        polarity_in = 1'b1;
  logic        start_conversion = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        reference_switch, osc_square_out, conversion_complete;
  logic        overflow_out, sign_out, irq, pready, pslverr;
  logic [6:0]  segments;
  logic [3:0]  digit_select;
  logic [31:0] prdata, q;
  logic        e;
  logic [27:0] shown;
  int          gap_len, lit_len, bad_select, n;
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #20 clock = ~clock;

  dvm_conversion_display_mux #(.CONV_CYCLES(CONV), .OSC_DIV(DIV)) uut (
    .clock(clock), .reset(reset), .clock_en(clock_en), .comparator_in(comparator_in),
    .polarity_in(polarity_in), .ext_clock_in(1'b0), .start_conversion(start_conversion),
    .reference_switch(reference_switch), .osc_square_out(osc_square_out),
    .conversion_complete(conversion_complete), .overflow_out(overflow_out),
    .sign_out(sign_out), .segments(segments), .digit_select(digit_select), .irq(irq),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  led_display_model display (
    .clock(clock), .segments(segments), .digit_select(digit_select), .shown(shown),
    .gap_len(gap_len), .lit_len(lit_len), .bad_select(bad_select)
  );

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic wait_clk(input int k);
    repeat (k) @(posedge clock);
  endtask

  // Called just after an edge; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && k < 50)
    begin
      @(posedge clock);
      k++;
    end
    check(k < 50, "apb wait timed out");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic test_regs();
    apb(1'b0, dvm_pkg::CTRL_OFS, 32'h0);
    check(q[0] === dvm_pkg::CTRL_RC_RESET, "rc mode reset value");
    apb(1'b0, dvm_pkg::IRQ_MASK_OFS, 32'h0);
    check(q[2:0] === dvm_pkg::IRQ_MASK_RESET, "mask reset value");
    apb(1'b0, 8'h20, 32'h0);
    check(e === 1'b1 && q === 32'h0000_0000, "unmapped read not refused");
    apb(1'b1, dvm_pkg::STATUS_OFS, 32'hFFFF_FFFF);
    apb(1'b0, dvm_pkg::STATUS_OFS, 32'h0);
    check(q[3:0] === 4'h0, "status took a write");
    $display("test regs done");
  endtask

  task automatic test_scan(input logic [27:0] expect_seg);
    wait_clk(2200);
    check(shown === expect_seg, "displayed digits");
    check(gap_len === dvm_pkg::GAP_CYCLES * DIV, "interdigit gap length");
    check(lit_len === (dvm_pkg::SCAN_CYCLES - dvm_pkg::GAP_CYCLES) * DIV, "scan");
    check(bad_select === 0, "more than one digit lit");
    $display("test scan done");
  endtask

  // Comparator high since reset: three ticks lost to sync, window is CONV-512 ticks
  task automatic test_conversion();
    start_conversion <= 1'b1;
    wait_clk(4);
    start_conversion <= 1'b0;
    wait_clk(8);
    check(conversion_complete === 1'b0, "complete not low after start");
    apb(1'b0, dvm_pkg::STATUS_OFS, 32'h0);
    check(q[3] === 1'b1, "start edge not pending");
    n = 0;
    while (conversion_complete !== 1'b1 && n < 2 * CONV * DIV)
    begin
      @(posedge clock);
      n++;
    end
    check(n / DIV >= 256 && n / DIV <= CONV, "start to complete");
    n = 0;
    while (conversion_complete === 1'b1 && n < 400)
    begin
      @(posedge clock);
      n++;
    end
    check(n === dvm_pkg::DONE_CYCLES * DIV, "complete pulse width");
    check(overflow_out === 1'b0, "overflow below full scale");
    check(sign_out === 1'b1, "sign not positive");
    apb(1'b0, dvm_pkg::RESULT_OFS, 32'h0);
    check(q[15:0] === 16'h0991, "result count");
    $display("test conversion done");
  endtask

  task automatic test_irq();
    apb(1'b0, dvm_pkg::IRQ_STAT_OFS, 32'h0);
    check(q[2:0] === 3'b101 && irq === 1'b0, "events or masked irq");
    apb(1'b1, dvm_pkg::IRQ_MASK_OFS, 32'h4);
    wait_clk(3);
    check(irq === 1'b1, "unmasked irq low");
    apb(1'b1, dvm_pkg::IRQ_STAT_OFS, 32'h4);
    wait_clk(3);
    check(irq === 1'b0, "irq after clear");
    apb(1'b0, dvm_pkg::IRQ_STAT_OFS, 32'h0);
    check(q[2:0] === 3'b001, "clear hit other bits");
    $display("test irq done");
  endtask

  task automatic test_modulator_osc();
    logic last;
    comparator_in <= 1'b0;
    wait_clk(10);
    check(reference_switch === 1'b0, "switch stuck at reference");
    comparator_in <= 1'b1;
    wait_clk(10);
    check(reference_switch === 1'b1, "switch stuck at ground");
    clock_en <= 1'b0;
    comparator_in <= 1'b0;
    wait_clk(10);
    check(reference_switch === 1'b1, "clock enable low did not freeze");
    clock_en <= 1'b1;
    comparator_in <= 1'b1;
    wait_clk(10);
    n = 0;
    last = osc_square_out;
    repeat (64)
    begin
      @(posedge clock);
      if (osc_square_out === 1'b1 && last === 1'b0)
        n++;
      last = osc_square_out;
    end
    check(n >= 64 / DIV - 1 && n <= 64 / DIV + 1, "square out rate");
    apb(1'b1, dvm_pkg::CTRL_OFS, 32'h0);
    wait_clk(4);
    check(osc_square_out === 1'b0, "square out in external mode");
    apb(1'b1, dvm_pkg::CTRL_OFS, 32'h1);
    $display("test modulator done");
  endtask

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: timeout", $time);
      report_and_stop();
    end
  end

  initial
  begin
    wait_clk(20);
    reset <= 1'b0;
    wait_clk(2);
    test_scan({7'h00, 7'h3F, 7'h3F, 7'h3F});
    test_regs();
    test_conversion();
    test_scan({7'h00, 7'h6F, 7'h6F, 7'h06});
    test_irq();
    test_modulator_osc();
    report_and_stop();
  end
endmodule // dvm_conversion_display_mux_bench
`default_nettype wire

// ===== dvm_input_sync.sv
// Three-stage synchroniser; output moves once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module dvm_input_sync (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic clock_en,
  input  wire logic async_in,
  output logic      sync_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      s1_q     <= 1'b0;
      s2_q     <= 1'b0;
      s3_q     <= 1'b0;
      sync_out <= 1'b0;
    end
    else if (clock_en)
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        sync_out <= s3_q;
    end
  end
endmodule // dvm_input_sync
`default_nettype wire

// ===== dvm_pkg.sv
// Shared constants and types for the voltmeter conversion and display block
package dvm_pkg;

  // Counter chain, in conversion-clock cycles
  localparam int unsigned CONV_CYCLES   = 64512;
  localparam int unsigned WINDOW_CYCLES = 64000;
  localparam int unsigned XFER_POINT    = 64256;
  localparam int unsigned SCAN_CYCLES   = 256;
  localparam int unsigned GAP_DIVISOR   = 32;
  localparam int unsigned GAP_CYCLES    = SCAN_CYCLES / GAP_DIVISOR;
  localparam int unsigned DONE_CYCLES   = 64;
  localparam int unsigned PRESCALE      = 32;
  localparam int unsigned FULL_SCALE    = 2000;
  localparam int unsigned OSC_DIV       = 64;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] STATUS_OFS    = 8'h04;
  localparam logic [7:0] RESULT_OFS    = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h10;

  // Field positions
  localparam int unsigned CTRL_RC_BIT     = 0;
  localparam int unsigned CTRL_START_BIT  = 1;
  localparam int unsigned EV_DONE_BIT     = 0;
  localparam int unsigned EV_OVER_BIT     = 1;
  localparam int unsigned EV_START_BIT    = 2;
  localparam int unsigned EV_WIDTH        = 3;

  // Reset values
  localparam logic        CTRL_RC_RESET   = 1'b1;
  localparam logic [2:0]  IRQ_MASK_RESET  = 3'h0;

  typedef enum logic [3:0] {
    GLYPH_0     = 4'h0,
    GLYPH_9     = 4'h9,
    GLYPH_BLANK = 4'hA,
    GLYPH_MINUS = 4'hB,
    GLYPH_O     = 4'hC,
    GLYPH_F     = 4'hD,
    GLYPH_L     = 4'hE
  } glyph_t;

  typedef struct packed {
    logic             sign;
    logic             overflow;
    logic [3:0][3:0]  digits;
  } result_t;

endpackage

// ===== dvm_seg_decode.sv
// Glyph code to seven-segment pattern, segments {g,f,e,d,c,b,a}
`timescale 1ns/100ps
`default_nettype none
module dvm_seg_decode (
  input  wire logic [3:0] glyph,
  output logic      [6:0] segments
);
  always_comb
  begin
    case (glyph)
      4'h0: segments = 7'h3F;
      4'h1: segments = 7'h06;
      4'h2: segments = 7'h5B;
      4'h3: segments = 7'h4F;
      4'h4: segments = 7'h66;
      4'h5: segments = 7'h6D;
      4'h6: segments = 7'h7D;
      4'h7: segments = 7'h07;
      4'h8: segments = 7'h7F;
      4'h9: segments = 7'h6F;
      4'hB: segments = 7'h40;
      4'hC: segments = 7'h3F;
      4'hD: segments = 7'h71;
      4'hE: segments = 7'h38;
      default: segments = 7'h00;
    endcase
  end
endmodule // dvm_seg_decode
`default_nettype wire

// ===== led_display_model.sv
// Behavioural multiplexed LED display: keeps each digit's segments, times scan runs
`timescale 1ns/100ps
`default_nettype none
module led_display_model (
  input  wire logic       clock,
  input  wire logic [6:0] segments,
  input  wire logic [3:0] digit_select,
  output var logic [27:0] shown,
  output var int          gap_len,
  output var int          lit_len,
  output var int          bad_select
);
  int         run;
  logic [3:0] prev;

  initial
  begin
    shown = '0;
    gap_len = 1000000;
    lit_len = 0;
    bad_select = 0;
    run = 0;
    prev = 4'h0;
  end

  always @(posedge clock)
  begin
    // Two lit digits at once would smear the display
    if (digit_select != 4'h0 && !$onehot(digit_select))
      bad_select <= bad_select + 1;
    for (int i = 0; i < 4; i++)
      if (digit_select[i])
        shown[i*7 +: 7] <= segments;
    if (digit_select == prev)
      run <= run + 1;
    else
    begin
      // Shortest dark run is the gap; a blanked leading digit keeps its select, so it times as a lit run
      if (prev == 4'h0 && run < gap_len)
        gap_len <= run;
      else if (prev != 4'h0)
        lit_len <= run;
      run <= 1;
    end
    prev <= digit_select;
  end
endmodule // led_display_model
`default_nettype wire
